// ===== verilog/cti_pkg.sv
// package for the condition test, ccr update and table interpolation unit
// assumes the core decoder supplies decoded operations and operand values
package cti_pkg;

	// ccr bit positions (x n z v c in the low five bits)
	localparam int CCR_C = 0;
	localparam int CCR_V = 1;
	localparam int CCR_Z = 2;
	localparam int CCR_N = 3;
	localparam int CCR_X = 4;
	// implemented ccr bits; the upper three read as zero
	localparam logic [7:0] CCR_MASK  = 8'h1f;
	localparam logic [7:0] CCR_RESET = 8'h00;

	// independent variable fields
	localparam int OFS_MSB  = 15;
	localparam int OFS_LSB  = 8;
	localparam int FRAC_MSB = 7;
	localparam int FRAC_LSB = 0;
	// fraction scale is 256, so the radix point sits 8 bits up
	localparam int FRAC_BITS = 8;

	// cycles of a non-table operation: request edge to response edge
	localparam int SINGLE_CYCLES = 1;

	// decoded operation kinds
	typedef enum logic [3:0] {
		OP_COND_TEST,
		OP_CONDITIONAL_TRAP,
		OP_TRAP_ON_OVERFLOW,
		OP_AND_IMMEDIATE,
		OP_XOR_IMMEDIATE,
		OP_OR_IMMEDIATE,
		OP_TABLE_SIGNED_ROUNDED,
		OP_TABLE_SIGNED_UNROUNDED,
		OP_TABLE_UNSIGNED_ROUNDED,
		OP_TABLE_UNSIGNED_UNROUNDED
	} cti_op_type;

	// operand size
	typedef enum logic [1:0] {
		SZ_BYTE,
		SZ_WORD,
		SZ_LONG
	} cti_size_type;

	// request from decoder and operand fetch
	typedef struct packed {
		logic         valid;
		cti_op_type   op;
		logic [3:0]   cond;
		logic [7:0]   imm8;
		cti_size_type size;
		logic [15:0]  indep;
		logic         use_regs;
		logic [31:0]  base;
		logic [31:0]  ep_lo;
		logic [31:0]  ep_hi;
	} cti_req_type;

	// response back to the core
	typedef struct packed {
		logic        done;
		logic        cond_true;
		logic        trap;
		logic        ovf_trap;
		logic [31:0] result;
	} cti_rsp_type;

endpackage

// ===== verilog/cti_core.sv
// condition tests, trap decisions, ccr immediate logic and table interpolation
// assumes requests come from core logic on clk_sys_i and a simple memory port
// answers table fetches with a one-cycle ack carrying read data
//
// What this block does
// - condition tests are flag logic, one always true, one never true
// - encoding 0000 true; 0111 true on zero
// - encoding 0001 never true
// - conditional trap fires only on true condition
// - trap on overflow when overflow flag set
// - ccr and/xor/or with 8-bit immediate
// - signed interpolation, rounded and unrounded, all sizes
// - unsigned interpolation, rounded and unrounded, all sizes
// - memory table or register pair endpoints
// - offset bits 15..8, fraction 7..0, over 256
// - tables up to 257 entries, 16-bit index
// - signed rounding to nearest, ties to even
`timescale 1ns/100ps
module cti_core (
	// clock and reset
	input  wire logic                clk_sys_i,
	input  wire logic                rstn_i,
	// decoded request
	input  wire cti_pkg::cti_req_type req_i,
	// direct ccr load from other execution units
	input  wire logic                ccr_load_i,
	input  wire logic [7:0]          ccr_data_i,
	// table fetch port
	output logic                     mem_req_o,
	output logic [31:0]              mem_addr_o,
	output cti_pkg::cti_size_type    mem_size_o,
	input  wire logic                mem_ack_i,
	input  wire logic [31:0]         mem_rdata_i,
	// status and answers
	output logic                     busy_o,
	output logic [7:0]               ccr_o,
	output cti_pkg::cti_rsp_type     rsp_o
);

	// table sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH0,
		ST_FETCH1,
		ST_CALC
	} cti_state_type;

	// condition evaluation over the ccr flags
	function automatic logic cond_eval(input logic [3:0] cc, input logic [7:0] f);
		logic c;
		logic v;
		logic z;
		logic n;
		logic r;
		c = f[cti_pkg::CCR_C];
		v = f[cti_pkg::CCR_V];
		z = f[cti_pkg::CCR_Z];
		n = f[cti_pkg::CCR_N];
		r = 1'b0;
		unique case (cc)
			4'h0: r = 1'b1;
			4'h1: r = 1'b0;
			4'h2: r = ~c & ~z;
			4'h3: r = c | z;
			4'h4: r = ~c;
			4'h5: r = c;
			4'h6: r = ~z;
			4'h7: r = z;
			4'h8: r = ~v;
			4'h9: r = v;
			4'ha: r = ~n;
			4'hb: r = n;
			4'hc: r = ~(n ^ v);
			4'hd: r = n ^ v;
			4'he: r = ~(n ^ v) & ~z;
			4'hf: r = z | (n ^ v);
		endcase
		return r;
	endfunction
	// extend an entry to 34 bits by size and signedness
	function automatic logic [33:0] entry_ext(input logic [31:0] v,
			input cti_pkg::cti_size_type sz, input logic sgn);
		logic [33:0] e;
		e = 34'h0;
		unique case (sz)
			cti_pkg::SZ_BYTE: e = {{26{sgn & v[7]}}, v[7:0]};
			cti_pkg::SZ_WORD: e = {{18{sgn & v[15]}}, v[15:0]};
			cti_pkg::SZ_LONG: e = {{2{sgn & v[31]}}, v};
			default:          e = 34'h0;
		endcase
		return e;
	endfunction
	// bytes per entry as a shift amount
	function automatic logic [1:0] size_shift(input cti_pkg::cti_size_type sz);
		logic [1:0] s;
		s = 2'h0;
		unique case (sz)
			cti_pkg::SZ_BYTE: s = 2'h0;
			cti_pkg::SZ_WORD: s = 2'h1;
			cti_pkg::SZ_LONG: s = 2'h2;
			default:          s = 2'h0;
		endcase
		return s;
	endfunction
	// registered state
	cti_state_type        state_q, state_d;   // sequencer
	cti_pkg::cti_req_type op_q, op_d;         // captured table request
	logic [31:0]          e0_q, e0_d;         // entry n
	logic [31:0]          e1_q, e1_d;         // entry n+1
	logic [7:0]           ccr_q, ccr_d;       // condition code register
	cti_pkg::cti_rsp_type rsp_q, rsp_d;       // response register
	// interpolation datapath
	logic [33:0]        x0;        // extended entry n
	logic [33:0]        x1;        // extended entry n+1
	logic [33:0]        diff;      // entry(n+1) - entry(n)
	logic signed [42:0] prod;      // diff times fraction
	logic signed [42:0] acc;       // entry(n)*256 + prod
	logic [34:0]        ipart;     // integer part
	logic [7:0]         fpart;     // fraction part
	logic               sgn_op;    // signed variant
	logic               rnd_op;    // rounded variant
	logic               rnd_up;    // increment for rounding
	logic [34:0]        rounded;   // rounded integer
	logic [33:0]        rnd_ext;   // rounded integer, sized
	logic [31:0]        tbl_res;   // final result, sized when rounded
	logic [31:0]        ent_addr;  // address of entry n
	logic               is_table;  // request is a table op
	logic [7:0]         frac;      // fraction field
	// offset and fraction fields of the independent variable
	assign frac   = op_q.indep[cti_pkg::FRAC_MSB:cti_pkg::FRAC_LSB];
	assign sgn_op = (op_q.op == cti_pkg::OP_TABLE_SIGNED_ROUNDED) |
	                (op_q.op == cti_pkg::OP_TABLE_SIGNED_UNROUNDED);
	assign rnd_op = (op_q.op == cti_pkg::OP_TABLE_SIGNED_ROUNDED) |
	                (op_q.op == cti_pkg::OP_TABLE_UNSIGNED_ROUNDED);
	// entry n address; 8-bit offset reaches 257-entry tables
	// entry n+1 of offset 255 is the 257th entry
	assign ent_addr = op_q.base +
		({24'h0, op_q.indep[cti_pkg::OFS_MSB:cti_pkg::OFS_LSB]} << size_shift(op_q.size));
	assign is_table = (req_i.op == cti_pkg::OP_TABLE_SIGNED_ROUNDED) |
	                  (req_i.op == cti_pkg::OP_TABLE_SIGNED_UNROUNDED) |
	                  (req_i.op == cti_pkg::OP_TABLE_UNSIGNED_ROUNDED) |
	                  (req_i.op == cti_pkg::OP_TABLE_UNSIGNED_UNROUNDED);

	// interpolation arithmetic, kept 43 bits wide so nothing overflows
	always_comb begin
		x0   = entry_ext(e0_q, op_q.size, sgn_op);
		x1   = entry_ext(e1_q, op_q.size, sgn_op);
		diff = x1 - x0;
		prod  = $signed({{9{diff[33]}}, diff}) * $signed({35'h0, frac});
		acc   = $signed({{1{x0[33]}}, x0, 8'h00}) + prod;
		ipart = acc[42:cti_pkg::FRAC_BITS];
		fpart = acc[cti_pkg::FRAC_BITS-1:0];
		// nearest, halfway goes to even for signed
		if (sgn_op) begin
			rnd_up = fpart[7] & ((|fpart[6:0]) | ipart[0]);
		end else begin
			// unsigned halfway rounds up
			rnd_up = fpart[7];
		end
		rounded = ipart + {34'h0, rnd_up};
		rnd_ext = entry_ext(rounded[31:0], op_q.size, sgn_op);
		// rounded forms take the sized result, unrounded forms the raw sum
		if (rnd_op) begin
			tbl_res = rnd_ext[31:0];
		end else begin
			// unrounded keeps 8 fraction bits below the radix point
			tbl_res = acc[31:0];
		end
	end

	// next-state logic for sequencer, ccr and response
	always_comb begin
		state_d    = state_q;
		op_d       = op_q;
		e0_d       = e0_q;
		e1_d       = e1_q;
		ccr_d      = ccr_q;
		rsp_d      = '0;
		mem_req_o  = 1'b0;
		mem_addr_o = ent_addr;
		mem_size_o = op_q.size;
		// outside ops may load ccr; own immediate ops below take priority
		if (ccr_load_i) begin
			ccr_d = ccr_data_i & cti_pkg::CCR_MASK;
		end
		unique case (state_q)
			ST_IDLE: begin
				if (req_i.valid) begin
					// every op reports its condition result
					rsp_d.cond_true = cond_eval(req_i.cond, ccr_q);
					unique case (req_i.op)
						cti_pkg::OP_COND_TEST: begin
							rsp_d.done = 1'b1;
						end
						cti_pkg::OP_CONDITIONAL_TRAP: begin
							rsp_d.trap = cond_eval(req_i.cond, ccr_q);
							rsp_d.done = 1'b1;
						end
						cti_pkg::OP_TRAP_ON_OVERFLOW: begin
							// overflow trap on v, else continue
							rsp_d.ovf_trap = ccr_q[cti_pkg::CCR_V];
							rsp_d.done     = 1'b1;
						end
						cti_pkg::OP_AND_IMMEDIATE: begin
							ccr_d      = (ccr_q & req_i.imm8) & cti_pkg::CCR_MASK;
							rsp_d.done = 1'b1;
						end
						cti_pkg::OP_XOR_IMMEDIATE: begin
							ccr_d      = (ccr_q ^ req_i.imm8) & cti_pkg::CCR_MASK;
							rsp_d.done = 1'b1;
						end
						cti_pkg::OP_OR_IMMEDIATE: begin
							ccr_d      = (ccr_q | req_i.imm8) & cti_pkg::CCR_MASK;
							rsp_d.done = 1'b1;
						end
						default: begin
							// illegal op codes are answered as a plain test
							if (is_table) begin
								op_d = req_i;
								if (req_i.use_regs) begin
									e0_d    = req_i.ep_lo;
									e1_d    = req_i.ep_hi;
									state_d = ST_CALC;
								end else begin
									state_d = ST_FETCH0;
								end
								rsp_d.done = 1'b0;
							end else begin
								rsp_d.done = 1'b1;
							end
						end
					endcase
				end
			end
			ST_FETCH0: begin
				mem_req_o = 1'b1;
				if (mem_ack_i) begin
					e0_d    = mem_rdata_i;
					state_d = ST_FETCH1;
				end
			end
			ST_FETCH1: begin
				// fetch entry n+1, one entry further on
				mem_req_o  = 1'b1;
				mem_addr_o = ent_addr + (32'h1 << size_shift(op_q.size));
				if (mem_ack_i) begin
					e1_d    = mem_rdata_i;
					state_d = ST_CALC;
				end
			end
			ST_CALC: begin
				// one cycle for the datapath, then answer
				rsp_d.done      = 1'b1;
				rsp_d.cond_true = cond_eval(op_q.cond, ccr_q);
				rsp_d.result    = tbl_res;
				state_d         = ST_IDLE;
			end
		endcase
	end

	// registers only
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			state_q <= ST_IDLE;
			op_q    <= '0;
			e0_q    <= 32'h0;
			e1_q    <= 32'h0;
			ccr_q   <= cti_pkg::CCR_RESET;
			rsp_q   <= '0;
		end else begin
			state_q <= state_d;
			op_q    <= op_d;
			e0_q    <= e0_d;
			e1_q    <= e1_d;
			ccr_q   <= ccr_d;
			rsp_q   <= rsp_d;
		end
	end

	// outputs
	assign busy_o = (state_q != ST_IDLE);
	assign ccr_o  = ccr_q;
	assign rsp_o  = rsp_q;

endmodule // cti_core

// ===== test/cti_core_assertions.sv
// port checker for cti_core
// assumes it is bound onto each cti_core instance
`timescale 1ns/100ps
module cti_core_assertions (
	// watched ports
	input wire logic                  clk_sys_i,
	input wire logic                  rstn_i,
	input wire cti_pkg::cti_req_type  req_i,
	input wire logic                  ccr_load_i,
	input wire logic [7:0]            ccr_data_i,
	input wire logic                  mem_req_o,
	input wire logic [31:0]           mem_addr_o,
	input wire cti_pkg::cti_size_type mem_size_o,
	input wire logic                  mem_ack_i,
	input wire logic [31:0]           mem_rdata_i,
	input wire logic                  busy_o,
	input wire logic [7:0]            ccr_o,
	input wire cti_pkg::cti_rsp_type  rsp_o
);
	// request taken at this edge
	logic        tk;
	// entry n address of the request offered at the previous edge
	logic [31:0] adr_q;
	assign tk = req_i.valid && !busy_o;
	// held one cycle so it lines up with the first fetch
	always_ff @(posedge clk_sys_i) begin
		adr_q <= req_i.base + (32'(req_i.indep[15:8]) << req_i.size);
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	a_and_ccr_update: assert property (
		tk && req_i.op == cti_pkg::OP_AND_IMMEDIATE |=>
		ccr_o == ($past(ccr_o) & $past(req_i.imm8) & 8'h1f)) else $error("and ccr wrong");
	a_true_cond: assert property (
		tk && req_i.op == cti_pkg::OP_COND_TEST && req_i.cond == 4'h0 |=>
		rsp_o.done && rsp_o.cond_true) else $error("true cond wrong");
	a_false_cond: assert property (
		tk && req_i.cond == 4'h1 |=> !rsp_o.cond_true) else $error("false cond true");
	a_equal_cond: assert property (
		tk && req_i.op == cti_pkg::OP_COND_TEST && req_i.cond == 4'h7 |=>
		rsp_o.cond_true == $past(ccr_o[2])) else $error("equal cond wrong");
	a_trap_cond: assert property (
		tk && req_i.op == cti_pkg::OP_CONDITIONAL_TRAP && req_i.cond[3:1] == 3'h0 |=>
		rsp_o.done && rsp_o.trap == !$past(req_i.cond[0])) else $error("trap wrong");
	a_ovf_trap: assert property (
		tk && req_i.op == cti_pkg::OP_TRAP_ON_OVERFLOW |=>
		rsp_o.done && rsp_o.ovf_trap == $past(ccr_o[1])) else $error("ovf trap wrong");
	a_pair_timing: assert property (
		tk && req_i.use_regs && req_i.op >= cti_pkg::OP_TABLE_SIGNED_ROUNDED |=>
		busy_o && !rsp_o.done ##1 rsp_o.done) else $error("pair timing wrong");
	a_first_fetch: assert property (
		tk && !req_i.use_regs && req_i.op >= cti_pkg::OP_TABLE_SIGNED_ROUNDED |=>
		mem_req_o && mem_addr_o == adr_q) else $error("fetch address wrong");
	a_fetch_size: assert property (
		tk && !req_i.use_regs && req_i.op >= cti_pkg::OP_TABLE_SIGNED_ROUNDED |=>
		mem_size_o == $past(req_i.size)) else $error("fetch size wrong");
endmodule // cti_core_assertions
bind cti_core cti_core_assertions cti_core_assertions_i (.clk_sys_i(clk_sys_i),
	.rstn_i(rstn_i), .req_i(req_i), .ccr_load_i(ccr_load_i), .ccr_data_i(ccr_data_i),
	.mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o),
	.mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o),
	.ccr_o(ccr_o), .rsp_o(rsp_o));

// ===== test/cti_mem_model.sv
// table memory model for the cti_core fetch port
// assumes the entry at address a reads as a times 3
`timescale 1ns/100ps
module cti_mem_model (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	// fetch port
	input  wire logic        mem_req_i,
	input  wire logic [31:0] mem_addr_i,
	input  wire logic [3:0]  stall_i,
	output logic             mem_ack_o,
	output logic [31:0]      mem_rdata_o
);
	// cycles waited on this fetch
	logic [3:0] cnt_q;
	// data flips outside the ack so a stale word never passes
	always_ff @(posedge clk_sys_i) begin
		mem_ack_o <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o;
		cnt_q <= 4'h0;
		if (!rstn_i) begin
			mem_rdata_o <= 32'h0;
		end else if (mem_req_i && !mem_ack_o) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == stall_i) begin
				mem_ack_o <= 1'b1;
				mem_rdata_o <= mem_addr_i * 32'h3;
			end
		end
	end
endmodule // cti_mem_model

// ===== test/cti_core_tb_top.sv
// bench for cti_core: conditions, traps, ccr immediates, interpolation
// assumes cti_mem_model answers the table fetches
`timescale 1ns/100ps
module cti_core_tb_top;
	// design ports
	logic                  clk_sys_i = 1'b0;
	logic                  rstn_i = 1'b0;
	cti_pkg::cti_req_type  req_i = '0;
	logic                  ccr_load_i = 1'b0;
	logic [7:0]            ccr_data_i = 8'h00;
	logic                  mem_req_o, mem_ack_i, busy_o;
	logic [31:0]           mem_addr_o, mem_rdata_i;
	cti_pkg::cti_size_type mem_size_o;
	logic [7:0]            ccr_o;
	cti_pkg::cti_rsp_type  rsp_o, rs;
	// bench state
	logic [3:0]            stall = 4'h0;
	int                    n_errors = 0;
	int                    comparisons = 0;
	always #20 clk_sys_i = ~clk_sys_i;
	cti_core cti_core_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req_i),
		.ccr_load_i(ccr_load_i), .ccr_data_i(ccr_data_i), .mem_req_o(mem_req_o),
		.mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o), .mem_ack_i(mem_ack_i),
		.mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .ccr_o(ccr_o), .rsp_o(rsp_o));
	cti_mem_model cti_mem_model_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .stall_i(stall),
		.mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask
	// one request, then wait for done; base fixed at 32'h100
	task automatic run(input int o, input int cd, input int s, input logic [15:0] ix,
		input logic rg, input logic [31:0] lo, input logic [31:0] hi);
		int k;
		@(posedge clk_sys_i) req_i <= '{1'b1, cti_pkg::cti_op_type'(o), 4'(cd), 8'hf6,
			cti_pkg::cti_size_type'(s), ix, rg, 32'h100, lo, hi};
		@(posedge clk_sys_i) req_i.valid <= 1'b0;
		#1;
		for (k = 0; k < 30 && rsp_o.done !== 1'b1; k++) @(posedge clk_sys_i) #1;
		rs = rsp_o;
		chk(32'(rs.done), 32'h1);
	endtask
	task automatic setccr(input int v);
		@(posedge clk_sys_i) ccr_load_i <= 1'b1;
		ccr_data_i <= 8'(v);
		@(posedge clk_sys_i) ccr_load_i <= 1'b0;
	endtask
	// pairs of codes are complements, so only the even half is listed
	function automatic logic cexp(int c, int f);
		logic t;
		case (c / 2)
			0: t = 1'b1;
			1: t = !f[0] && !f[2];
			2: t = !f[0];
			3: t = !f[2];
			4: t = !f[1];
			5: t = !f[3];
			6: t = f[3] == f[1];
			default: t = f[3] == f[1] && !f[2];
		endcase
		return t ^ c[0];
	endfunction
	function automatic longint ext(logic [31:0] v, int s, logic sg);
		if (s == 0) return sg ? longint'($signed(v[7:0])) : longint'(v[7:0]);
		if (s == 1) return sg ? longint'($signed(v[15:0])) : longint'(v[15:0]);
		return sg ? longint'($signed(v)) : longint'(v);
	endfunction
	// op 6..9: signed/unsigned, even codes rounded
	function automatic logic [31:0] texp(int o, int s, logic [31:0] lo, logic [31:0] hi,
		logic [7:0] f);
		longint a, b;
		a = ext(lo, s, o < 8);
		b = ext(hi, s, o < 8);
		a = a * 256 + longint'(f) * (b - a);
		if (o[0]) return a[31:0];
		b = a >>> 8;
		if (a[7:0] > 128 || (a[7:0] == 128 && (o >= 8 || b[0]))) b++;
		a = ext(b[31:0], s, o < 8);
		return a[31:0];
	endfunction
	task automatic t_cond;
		for (int v = 0; v < 32; v++) begin
			setccr(v);
			for (int c = 0; c < 16; c++) begin
				run(0, c, 0, 16'h0, 1'b0, 32'h0, 32'h0);
				chk(32'(rs.cond_true), 32'(cexp(c, v)));
				run(1, c, 0, 16'h0, 1'b0, 32'h0, 32'h0);
				chk(32'(rs.trap), 32'(cexp(c, v)));
			end
			run(2, 0, 0, 16'h0, 1'b0, 32'h0, 32'h0);
			chk(32'(rs.ovf_trap), 32'(v[1]));
		end
		$display("t_cond done");
	endtask
	// ccr 0d with immediate f6: and 04, xor 1b, or 1f
	task automatic t_imm;
		logic [7:0] e [3] = '{8'h04, 8'h1b, 8'h1f};
		for (int i = 0; i < 3; i++) begin
			setccr(8'h0d);
			run(3 + i, 0, 0, 16'h0, 1'b0, 32'h0, 32'h0);
			chk(32'(ccr_o), 32'(e[i]));
		end
		$display("t_imm done");
	endtask
	// exact, even and odd halfway, negative spans through the register pair
	task automatic t_pair;
		logic [31:0] lo [4] = '{32'h685, 32'h686, 32'hfffffff0, 32'h685};
		logic [31:0] hi [4] = '{32'h68f, 32'h687, 32'h10, 32'h686};
		logic [15:0] ix [4] = '{16'ha380, 16'h0080, 16'h0040, 16'h0280};
		for (int o = 6; o < 10; o++)
			for (int s = 0; s < 3; s++)
				for (int k = 0; k < 4; k++) begin
					run(o, 0, s, ix[k], 1'b1, lo[k], hi[k]);
					chk(rs.result, texp(o, s, lo[k], hi[k], ix[k][7:0]));
				end
		$display("t_pair done");
	endtask
	// memory table with stalls; word case uses the last entry pair
	task automatic t_mem;
		logic [31:0] a;
		logic [7:0]  n;
		for (int s = 0; s < 3; s++) begin
			@(posedge clk_sys_i) stall <= 4'(2 * s);
			n = s == 1 ? 8'hff : 8'ha3;
			a = 32'h100 + (32'(n) << s);
			run(6 + s, 0, s, {n, 8'h5c}, 1'b0, 32'h0, 32'h0);
			chk(rs.result, texp(6 + s, s, a * 3, (a + (32'h1 << s)) * 3, 8'h5c));
		end
		$display("t_mem done");
	endtask
	task automatic print_verdict;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		t_cond;
		t_imm;
		t_pair;
		t_mem;
		print_verdict;
	end
	// watchdog well past the expected run length
	initial begin
		repeat (50000) @(posedge clk_sys_i);
		n_errors++;
		print_verdict;
	end
endmodule // cti_core_tb_top
